// ===== src/lpmc_ctrl.sv
// Purpose: Low-power mode controller merging CPU and radio requests.
// Assumes: Inputs synchronous to clk; reset_n async active low.
// Notes:   Reset means system/power-on reset; device starts in Run.
// Behaviour
// - Reset puts the device in Run; low modes only on software choice.
// - Sleep halts only the application CPU; only an interrupt event wakes it.
// - Low-power run uses LP regulator; CPU clock at most 2 MHz.
// - Low-power sleep only from Low-power run; wakes back to it.
// - Stop modes keep all RAM and registers; slow oscillator runs.
// - Stop 0 keeps main regulator; Stop 1 uses LP regulator; both share wake sources.
// - In Stop a wake-capable peripheral gets the fast RC on request.
// - Stop exit clock multispeed or fast RC; fast RC if radio used.
// - Standby powers off the regulator; brownout stays active.
// - Standby loses registers except backup; RAM retention optional.
// - Standby exits on reset pin, watchdog, wake pin, RTC, crystal fail.
// - After Standby wake the clock is 16 MHz fast RC.
// - During Standby each I/O holds its software-chosen pull state.
// - Shutdown powers off regulator and brownout; no backup switch.
// - Shutdown loses all RAM banks and registers except backup.
// - Shutdown exits on reset pin, wake pin or RTC only.
// - After Shutdown wake the clock is 4 MHz multispeed RC.
// - Hardware applies the higher-power of CPU and radio requests.
// - RTC may run in Stop, Standby, Shutdown and wakes the device.
// - In Stop the radio waits for events and may wake the system.
`timescale 1ns/1ns
`default_nettype none
`include "lpmc_defs.svh"
module lpmc_ctrl
  import lpmc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [2:0] mode_sel,
  input  wire logic       sleep_req,
  input  wire logic       sleep_deep,
  input  wire logic [2:0] radio_mode,
  input  wire logic       radio_wake,
  input  wire logic       irq_event,
  input  wire logic       stop_clk_hsi,
  input  wire logic       sram_retain,
  input  wire logic       rtc_enable,
  input  wire logic       rtc_event,
  input  wire logic       external_reset_pin,
  input  wire logic       independent_watchdog,
  input  wire logic       wakeup_pin,
  input  wire logic       wakeup_pol,
  input  wire logic       clock_failure_detector,
  input  wire logic       periph_hsi_req,
  input  wire logic [1:0] io_pull_cfg,
  output logic [2:0]      eff_mode,
  output logic            cpu_halt,
  output logic            main_reg_on,
  output logic            lp_reg_on,
  output logic            core_supply_domain_on,
  output logic            brownout_supervisor_on,
  output logic            backup_switch_en,
  output logic            low_speed_osc_on,
  output logic            fast_internal_rc_on,
  output logic            fast_rc_periph_grant,
  output logic            cpu_clk_limit_2mhz,
  output logic            ram_retain,
  output logic            reg_retain,
  output logic            rtc_run,
  output logic            io_hold,
  output logic [1:0]      io_pull,
  output logic [1:0]      sysclk_sel,
  output logic            from_standby,
  output logic            from_shutdown,
  output logic            from_stop
);
  lpmc_if arb_bus ();
  lpmc_arbiter u_arb (.req(arb_bus));

  logic [2:0]  cpu_mode_r, cpu_mode_nxt;
  lpmc_state_t seq_r, seq_nxt;
  logic [1:0]  clk_r, clk_nxt;
  logic [2:0]  flags_r, flags_nxt;
  logic        wpin_d_r;
  logic [1:0]  pull_r, pull_nxt;
  logic        edge_hit;
  logic        wake_any;
  logic [2:0]  eff;

  // Radio request passes through the arbiter beside the CPU request.
  assign arb_bus.cpu_mode   = cpu_mode_r;
  assign arb_bus.radio_mode = radio_mode;
  assign eff = arb_bus.eff_mode;

  // Polarity-selected edge of the wake pin.
  assign edge_hit = wakeup_pol ? (!wpin_d_r && wakeup_pin)
                               : (wpin_d_r && !wakeup_pin);

  // Wake sources differ per mode; Shutdown has no watchdog or crystal check.
  always_comb begin
    wake_any = 1'b0;
    case (cpu_mode_r)
      `LPMC_MODE_SLEEP, `LPMC_MODE_LPSLEEP:
        wake_any = irq_event;
      `LPMC_MODE_STOP0, `LPMC_MODE_STOP1:
        wake_any = irq_event || radio_wake || edge_hit
                   || (rtc_enable && rtc_event);
      `LPMC_MODE_STANDBY:
        wake_any = external_reset_pin || independent_watchdog || edge_hit
                   || (rtc_enable && rtc_event)
                   || clock_failure_detector;
      `LPMC_MODE_SHUTDOWN:
        wake_any = external_reset_pin || edge_hit
                   || (rtc_enable && rtc_event);
      default:
        wake_any = 1'b0;
    endcase
  end

  // Mode sequencing: requests, entry, wake and exit clock choice.
  always_comb begin
    cpu_mode_nxt = cpu_mode_r;
    seq_nxt      = seq_r;
    clk_nxt      = clk_r;
    flags_nxt    = flags_r;
    pull_nxt     = pull_r;
    case (seq_r)
      LPMC_SEQ_ACTIVE: begin
        if (sleep_req) begin
          // Light sleep keeps the current run flavour.
          if (!sleep_deep) begin
            cpu_mode_nxt = (cpu_mode_r == `LPMC_MODE_LPRUN) ?
                           `LPMC_MODE_LPSLEEP : `LPMC_MODE_SLEEP;
          end else begin
            cpu_mode_nxt = mode_sel;
          end
          // Low-power sleep may only be reached from Low-power run.
          if (cpu_mode_nxt == `LPMC_MODE_LPSLEEP
              && cpu_mode_r != `LPMC_MODE_LPRUN) begin
            cpu_mode_nxt = `LPMC_MODE_SLEEP;
          end
          if (cpu_mode_nxt == `LPMC_MODE_RUN
              || cpu_mode_nxt == `LPMC_MODE_LPRUN) begin
            seq_nxt = LPMC_SEQ_ACTIVE;
          end else begin
            seq_nxt = LPMC_SEQ_LOW;
          end
          pull_nxt = io_pull_cfg;
        end else if (mode_sel == `LPMC_MODE_LPRUN
                     || mode_sel == `LPMC_MODE_RUN) begin
          cpu_mode_nxt = mode_sel;
        end
      end
      LPMC_SEQ_LOW: begin
        if (wake_any) begin
          seq_nxt   = LPMC_SEQ_WAKE;
          flags_nxt = 3'h0;
          case (cpu_mode_r)
            `LPMC_MODE_STANDBY: begin
              clk_nxt      = `LPMC_CLK_HSI_16MHZ;
              flags_nxt[0] = 1'b1;
            end
            `LPMC_MODE_SHUTDOWN: begin
              clk_nxt      = `LPMC_CLK_MULTI_4MHZ;
              flags_nxt[1] = 1'b1;
            end
            `LPMC_MODE_STOP0, `LPMC_MODE_STOP1: begin
              // Radio in use forces the fast RC on Stop exit.
              clk_nxt = (stop_clk_hsi || radio_mode != `LPMC_MODE_SHUTDOWN)
                        ? `LPMC_CLK_HSI_16MHZ
                        : `LPMC_CLK_MULTI_48MHZ;
              flags_nxt[2] = 1'b1;
            end
            default: clk_nxt = clk_r;
          endcase
        end
      end
      LPMC_SEQ_WAKE: begin
        seq_nxt      = LPMC_SEQ_ACTIVE;
        cpu_mode_nxt = (cpu_mode_r == `LPMC_MODE_LPSLEEP) ?
                       `LPMC_MODE_LPRUN : `LPMC_MODE_RUN;
      end
      default: seq_nxt = LPMC_SEQ_ACTIVE;
    endcase
  end

  // State registers; reset lands in Run on the multispeed RC.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_mode_r <= `LPMC_MODE_RUN;
      seq_r      <= LPMC_SEQ_ACTIVE;
      clk_r      <= `LPMC_CLK_MULTI_4MHZ;
      flags_r    <= 3'h0;
      wpin_d_r   <= 1'b0;
      pull_r     <= 2'h0;
    end else begin
      cpu_mode_r <= cpu_mode_nxt;
      seq_r      <= seq_nxt;
      clk_r      <= clk_nxt;
      flags_r    <= flags_nxt;
      wpin_d_r   <= wakeup_pin;
      pull_r     <= pull_nxt;
    end
  end

  // Power and clock controls decoded from the merged mode; CPU halt follows the CPU request, clock select the sequencer.
  always_comb begin
    eff_mode               = eff;
    cpu_halt               = (cpu_mode_r != `LPMC_MODE_RUN
                              && cpu_mode_r != `LPMC_MODE_LPRUN);
    main_reg_on            = (eff >= `LPMC_MODE_STOP0)
                             && (eff != `LPMC_MODE_LPRUN)
                             && (eff != `LPMC_MODE_LPSLEEP);
    lp_reg_on              = (eff == `LPMC_MODE_LPRUN)
                             || (eff == `LPMC_MODE_LPSLEEP)
                             || (eff == `LPMC_MODE_STOP1)
                             || (eff == `LPMC_MODE_STANDBY
                                 && sram_retain);
    core_supply_domain_on  = (eff >= `LPMC_MODE_STOP1);
    brownout_supervisor_on = (eff != `LPMC_MODE_SHUTDOWN);
    backup_switch_en       = (eff != `LPMC_MODE_SHUTDOWN);
    low_speed_osc_on       = 1'b1;
    fast_rc_periph_grant   = periph_hsi_req
                             && (eff == `LPMC_MODE_STOP0
                                 || eff == `LPMC_MODE_STOP1);
    fast_internal_rc_on    = fast_rc_periph_grant
                             || (eff >= `LPMC_MODE_LPSLEEP);
    cpu_clk_limit_2mhz     = (eff == `LPMC_MODE_LPRUN)
                             || (eff == `LPMC_MODE_LPSLEEP);
    ram_retain             = (eff >= `LPMC_MODE_STOP1)
                             || (eff == `LPMC_MODE_STANDBY
                                 && sram_retain);
    reg_retain             = (eff >= `LPMC_MODE_STOP1);
    rtc_run                = rtc_enable;
    io_hold                = (eff == `LPMC_MODE_STANDBY);
    io_pull                = pull_r;
    sysclk_sel             = clk_r;
    from_standby           = flags_r[0];
    from_shutdown          = flags_r[1];
    from_stop              = flags_r[2];
  end

  // Merged mode never sits below either request.
  property p_merge;
    @(posedge clk) disable iff (!reset_n)
      (eff_mode >= cpu_mode_r) && (eff_mode >= radio_mode);
  endproperty
  a_merge: assert property (p_merge)
    else $error("Merge below request.");

  property p_standby_clk;
    @(posedge clk) disable iff (!reset_n)
      (seq_r == LPMC_SEQ_LOW && cpu_mode_r == `LPMC_MODE_STANDBY && wake_any)
      |=> (sysclk_sel == `LPMC_CLK_HSI_16MHZ) && from_standby;
  endproperty
  a_standby_clk: assert property (p_standby_clk)
    else $error("Standby clock.");

  property p_shut_clk;
    @(posedge clk) disable iff (!reset_n)
      (seq_r == LPMC_SEQ_LOW && cpu_mode_r == `LPMC_MODE_SHUTDOWN && wake_any)
      |=> (sysclk_sel == `LPMC_CLK_MULTI_4MHZ) && from_shutdown;
  endproperty
  a_shut_clk: assert property (p_shut_clk)
    else $error("Shutdown clock.");

  property p_shut_bor;
    @(posedge clk) disable iff (!reset_n)
      (eff_mode == `LPMC_MODE_SHUTDOWN) |-> !brownout_supervisor_on
      && !backup_switch_en && !core_supply_domain_on;
  endproperty
  a_shut_bor: assert property (p_shut_bor)
    else $error("Shutdown power.");

  property p_stby_bor;
    @(posedge clk) disable iff (!reset_n)
      (eff_mode == `LPMC_MODE_STANDBY) |-> brownout_supervisor_on
      && !core_supply_domain_on && !main_reg_on;
  endproperty
  a_stby_bor: assert property (p_stby_bor)
    else $error("Standby power.");

  property p_shut_no_wdg;
    @(posedge clk) disable iff (!reset_n)
      (seq_r == LPMC_SEQ_LOW && cpu_mode_r == `LPMC_MODE_SHUTDOWN
       && !external_reset_pin && !edge_hit && !rtc_event)
      |=> seq_r == LPMC_SEQ_LOW;
  endproperty
  a_shut_no_wdg: assert property (p_shut_no_wdg)
    else $error("Bad wake.");

  sequence s_lpsleep_wake;
    seq_r == LPMC_SEQ_LOW && cpu_mode_r == `LPMC_MODE_LPSLEEP && irq_event;
  endsequence
  property p_lpsleep_back;
    @(posedge clk) disable iff (!reset_n)
      s_lpsleep_wake |=> ##1 cpu_mode_r == `LPMC_MODE_LPRUN;
  endproperty
  a_lpsleep_back: assert property (p_lpsleep_back)
    else $error("LP wake.");

  property p_stop_grant;
    @(posedge clk) disable iff (!reset_n)
      (periph_hsi_req && eff_mode == `LPMC_MODE_STOP1)
      |-> fast_rc_periph_grant && fast_internal_rc_on;
  endproperty
  a_stop_grant: assert property (p_stop_grant)
    else $error("No grant.");

  property p_stop_retain;
    @(posedge clk) disable iff (!reset_n)
      (eff_mode == `LPMC_MODE_STOP0 || eff_mode == `LPMC_MODE_STOP1)
      |-> ram_retain && reg_retain && low_speed_osc_on;
  endproperty
  a_stop_retain: assert property (p_stop_retain)
    else $error("Stop loss.");
endmodule // lpmc_ctrl
`default_nettype wire

// ===== src/lpmc_defs.svh
// Purpose: Constants for the low-power mode controller.
// Assumes: 125 MHz system clock.
// Notes:   Mode codes are ordered by power, higher code means more power.
`ifndef LPMC_DEFS_SVH
`define LPMC_DEFS_SVH
`define LPMC_MODE_SHUTDOWN   3'h0
`define LPMC_MODE_STANDBY    3'h1
`define LPMC_MODE_STOP1      3'h2
`define LPMC_MODE_STOP0      3'h3
`define LPMC_MODE_LPSLEEP    3'h4
`define LPMC_MODE_LPRUN      3'h5
`define LPMC_MODE_SLEEP      3'h6
`define LPMC_MODE_RUN        3'h7
`define LPMC_CLK_MULTI_4MHZ  2'h0
`define LPMC_CLK_HSI_16MHZ   2'h1
`define LPMC_CLK_MULTI_48MHZ 2'h2
`define LPMC_LPRUN_MAX_KHZ   16'h07D0
`define LPMC_WAKE_SETTLE_CYC 4'h4
`endif

// ===== src/lpmc_pkg.sv
// Purpose: Types for the low-power mode controller.
// Assumes: Codes come from lpmc_defs.svh.
// Notes:   Mode value order encodes power rank.
package lpmc_pkg;
  typedef logic [2:0] lpmc_mode_t;
  typedef enum logic [1:0] {
    LPMC_SEQ_ACTIVE = 2'h0,
    LPMC_SEQ_LOW    = 2'h1,
    LPMC_SEQ_WAKE   = 2'h3
  } lpmc_state_t;
endpackage

// ===== src/lpmc_if.sv
// Purpose: Carries merged mode requests to the arbiter.
// Assumes: Single clock.
// Notes:   None.
`timescale 1ns/1ns
`default_nettype none
interface lpmc_if;
  logic [2:0] cpu_mode;
  logic [2:0] radio_mode;
  logic [2:0] eff_mode;
  modport ctrl (output cpu_mode, output radio_mode, input eff_mode);
  modport arb  (input cpu_mode, input radio_mode, output eff_mode);
endinterface
`default_nettype wire

// ===== src/lpmc_arbiter.sv
// Purpose: Picks the higher-power mode of two requesters.
// Assumes: Higher mode code means higher power.
// Notes:   Purely combinational.
`timescale 1ns/1ns
`default_nettype none
module lpmc_arbiter
  import lpmc_pkg::*;
(
  lpmc_if.arb req
);
  // Higher code wins so the radio never loses a state it still needs.
  always_comb begin
    req.eff_mode = (req.cpu_mode > req.radio_mode) ? req.cpu_mode
                                                   : req.radio_mode;
  end
endmodule // lpmc_arbiter
`default_nettype wire

// ===== verification/lpmc_far_model.sv
// Purpose: Far-side model of the radio power requester.
// Assumes: Bench stimulus settles before each rising edge.
// Notes:   Radio request drops when the application picks a radio-less mode.
`timescale 1ns/1ns
`default_nettype none
module lpmc_far_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [2:0] need_mode,
  input  wire logic [2:0] app_target,
  input  wire logic       evt,
  output logic [2:0]      radio_mode,
  output logic            radio_wake
);
  logic no_radio;
  // Software turns the radio off first, so the merge never hides a slip.
  assign no_radio = app_target inside {3'h0, 3'h1, 3'h4, 3'h5};
  // Requests change just after the rising edge, as the real stack does.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      radio_mode <= 3'h0;
      radio_wake <= 1'b0;
    end else begin
      radio_mode <= no_radio ? 3'h0 : need_mode;
      radio_wake <= evt;
    end
  end
endmodule // lpmc_far_model
`default_nettype wire

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the low-power mode controller.
// Assumes: Inputs change on the falling edge of clk.
// Notes:   Table rows cover plain entries; odd cases are written out.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct {
    logic [2:0] m, need, eff; logic deep, core, bor; logic [1:0] w;
  } lpmc_row_t;
  logic       clk, reset_n, sleep_req, sleep_deep, radio_wake, irq_event;
  logic       stop_clk_hsi, sram_retain, rtc_enable, rtc_event, ext_pin;
  logic       wdog, wakeup_pin, wakeup_pol, cfd, periph_hsi_req, radio_evt;
  logic [2:0] mode_sel, radio_mode, need, eff_mode;
  logic [1:0] io_pull_cfg, io_pull, sysclk_sel;
  logic       cpu_halt, main_reg_on, lp_reg_on, core_on, bor_on, bk_sw;
  logic       lso_on, frc_on, frc_gnt, clk_lim, ram_ret, reg_ret, rtc_run;
  logic       io_hold, from_standby, from_shutdown, from_stop;
  int         fail_count, cmp_count, tick;
  lpmc_row_t  rows[8];

  lpmc_far_model lpmc_far_model_inst (.clk(clk), .reset_n(reset_n),
    .need_mode(need), .app_target(mode_sel), .evt(radio_evt),
    .radio_mode(radio_mode), .radio_wake(radio_wake));
  lpmc_ctrl lpmc_ctrl_inst (.clk(clk), .reset_n(reset_n),
    .mode_sel(mode_sel), .sleep_req(sleep_req), .sleep_deep(sleep_deep),
    .radio_mode(radio_mode), .radio_wake(radio_wake), .irq_event(irq_event),
    .stop_clk_hsi(stop_clk_hsi), .sram_retain(sram_retain),
    .rtc_enable(rtc_enable), .rtc_event(rtc_event),
    .external_reset_pin(ext_pin), .independent_watchdog(wdog),
    .wakeup_pin(wakeup_pin), .wakeup_pol(wakeup_pol),
    .clock_failure_detector(cfd), .periph_hsi_req(periph_hsi_req),
    .io_pull_cfg(io_pull_cfg), .eff_mode(eff_mode), .cpu_halt(cpu_halt),
    .main_reg_on(main_reg_on), .lp_reg_on(lp_reg_on),
    .core_supply_domain_on(core_on), .brownout_supervisor_on(bor_on),
    .backup_switch_en(bk_sw), .low_speed_osc_on(lso_on),
    .fast_internal_rc_on(frc_on), .fast_rc_periph_grant(frc_gnt),
    .cpu_clk_limit_2mhz(clk_lim), .ram_retain(ram_ret),
    .reg_retain(reg_ret), .rtc_run(rtc_run), .io_hold(io_hold),
    .io_pull(io_pull), .sysclk_sel(sysclk_sel),
    .from_standby(from_standby), .from_shutdown(from_shutdown),
    .from_stop(from_stop));

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard: the whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    tick++;
    if (tick == 3000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [2:0] got, input logic [2:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Mode select leads the sleep pulse so the radio model can react.
  task automatic enter(input logic [2:0] m, input logic deep);
    mode_sel = m;
    sleep_deep = deep;
    cyc(2);
    sleep_req = 1'b1;
    cyc(1);
    sleep_req = 1'b0;
    cyc(1);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence: reset, table loop, then the awkward cases.
  initial begin
    {sleep_req, sleep_deep, irq_event, stop_clk_hsi, sram_retain} = '0;
    {rtc_event, ext_pin, wdog, wakeup_pin, cfd, periph_hsi_req} = '0;
    {radio_evt, wakeup_pol, rtc_enable, reset_n} = 4'h6;
    {mode_sel, need, io_pull_cfg} = 8'hE0;
    fail_count = 0;
    cmp_count = 0;
    tick = 0;
    rows = '{'{3'h6,3'h0,3'h6,1'b0,1'b1,1'b1,2'h0},
             '{3'h3,3'h0,3'h3,1'b1,1'b1,1'b1,2'h0},
             '{3'h2,3'h0,3'h2,1'b1,1'b1,1'b1,2'h0},
             '{3'h1,3'h0,3'h1,1'b1,1'b0,1'b1,2'h1},
             '{3'h0,3'h0,3'h0,1'b1,1'b0,1'b0,2'h2},
             '{3'h2,3'h7,3'h7,1'b1,1'b1,1'b1,2'h0},
             '{3'h2,3'h3,3'h3,1'b1,1'b1,1'b1,2'h0},
             '{3'h6,3'h2,3'h6,1'b0,1'b1,1'b1,2'h0}};
    cyc(2);
    reset_n = 1'b1;
    cyc(1);
    chk(eff_mode, 3'h7, "reset mode");
    chk({1'b0, sysclk_sel}, 3'h0, "reset clock");
    chk({from_stop, from_standby, from_shutdown}, 3'h0, "rst flags");
    $display("test reset done");
    foreach (rows[i]) begin
      need = rows[i].need;
      enter(rows[i].m, rows[i].deep);
      chk(eff_mode, rows[i].eff, "merged mode");
      chk({2'h0, core_on}, {2'h0, rows[i].core}, "core");
      chk({2'h0, bor_on}, {2'h0, rows[i].bor}, "brownout");
      chk({2'h0, cpu_halt}, 3'h1, "cpu halt");
      case (rows[i].w)
        2'h0: pulse(irq_event);
        2'h1: pulse(rtc_event);
        default: pulse(ext_pin);
      endcase
      cyc(3);
      chk(eff_mode, 3'h7, "back to run");
      chk({2'h0, cpu_halt}, 3'h0, "cpu running");
    end
    need = 3'h0;
    $display("test table done");
    sram_retain = 1'b1;
    io_pull_cfg = 2'h2;
    enter(3'h1, 1'b1);
    chk({io_hold, io_pull}, 3'h6, "standby pulls");
    chk({ram_ret, reg_ret, rtc_run}, 3'h5, "standby retain");
    pulse(wdog);
    cyc(3);
    chk({1'b0, sysclk_sel}, 3'h1, "standby wake clock");
    chk({2'h0, from_standby}, 3'h1, "standby flag");
    $display("test standby done");
    enter(3'h0, 1'b1);
    chk({bk_sw, ram_ret, reg_ret}, 3'h0, "shutdown losses");
    pulse(wdog);
    pulse(cfd);
    cyc(3);
    chk(eff_mode, 3'h0, "shutdown holds");
    wakeup_pin = 1'b1;
    cyc(3);
    chk({1'b0, sysclk_sel}, 3'h0, "shutdown wake clock");
    chk({2'h0, from_shutdown}, 3'h1, "shutdown flag");
    wakeup_pin = 1'b0;
    $display("test shutdown done");
    enter(3'h4, 1'b1);
    chk(eff_mode, 3'h6, "lp sleep refused");
    pulse(irq_event);
    mode_sel = 3'h5;
    cyc(4);
    chk(eff_mode, 3'h5, "lp run");
    chk({lp_reg_on, main_reg_on, clk_lim}, 3'h5, "lp run supply");
    enter(3'h4, 1'b1);
    chk(eff_mode, 3'h4, "lp sleep");
    pulse(irq_event);
    cyc(3);
    chk(eff_mode, 3'h5, "lp sleep wake");
    mode_sel = 3'h7;
    cyc(3);
    $display("test low-power run done");
    periph_hsi_req = 1'b1;
    enter(3'h3, 1'b1);
    chk({frc_gnt, frc_on, main_reg_on}, 3'h7, "stop0 fast rc");
    chk({ram_ret, reg_ret, lso_on}, 3'h7, "stop retain");
    pulse(radio_evt);
    cyc(4);
    chk(eff_mode, 3'h7, "radio wake");
    chk({1'b0, sysclk_sel}, 3'h2, "stop exit 48m");
    chk({2'h0, from_stop}, 3'h1, "stop flag");
    need = 3'h2;
    enter(3'h2, 1'b1);
    pulse(irq_event);
    cyc(3);
    chk({1'b0, sysclk_sel}, 3'h1, "stop exit radio");
    $display("test stop done");
    // A second reset in mid-run, while the device sits in Stop 0.
    need = 3'h0;
    enter(3'h3, 1'b1);
    reset_n = 1'b0;
    cyc(2);
    reset_n = 1'b1;
    cyc(1);
    chk(eff_mode, 3'h7, "rerun mode");
    chk({1'b0, sysclk_sel}, 3'h0, "rerun clock");
    chk({from_stop, from_standby, from_shutdown}, 3'h0, "rst flags");
    $display("test second reset done");
    // Software choice of the fast RC on Stop exit with the radio idle.
    stop_clk_hsi = 1'b1;
    enter(3'h2, 1'b1);
    pulse(irq_event);
    cyc(3);
    chk({1'b0, sysclk_sel}, 3'h1, "stop exit fast rc");
    stop_clk_hsi = 1'b0;
    $display("test stop clock choice done");
    // Clock failure wakes Standby; a falling pin edge wakes Shutdown.
    enter(3'h1, 1'b1);
    pulse(cfd);
    cyc(3);
    chk(eff_mode, 3'h7, "clock fail run");
    chk({2'h0, from_standby}, 3'h1, "clock fail wake");
    wakeup_pol = 1'b0;
    wakeup_pin = 1'b1;
    enter(3'h0, 1'b1);
    wakeup_pin = 1'b0;
    cyc(3);
    chk({1'b0, sysclk_sel}, 3'h0, "falling wake clock");
    chk({2'h0, from_shutdown}, 3'h1, "falling wake flag");
    $display("test wake sources done");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
